// *** rtl/csum_pkg.sv ***
package csum_pkg;

  // Packet store and length counters
  localparam int IDX_W = 11;
  localparam int LEN_W = 12;
  localparam int BUF_DEPTH = 2048;
  localparam logic [LEN_W-1:0] BUF_LEN = 12'h800;

  // Header length limits
  localparam logic [LEN_W-1:0] L2_LEN_MIN = 12'h00E;
  localparam logic [LEN_W-1:0] L2_LEN_MAX = 12'h07F;
  localparam logic [LEN_W-1:0] IP_LEN_MAX = 12'h1FF;
  localparam logic [LEN_W-1:0] IP_END_MAX = 12'h27E;
  localparam logic [LEN_W-1:0] SCTP_START_MIN = 12'h01A;

  // Insertion offsets past the start of each header
  localparam logic [LEN_W-1:0] IP_CSUM_OFF = 12'h00A;
  localparam logic [LEN_W-1:0] TCP_CSUM_OFF = 12'h010;
  localparam logic [LEN_W-1:0] UDP_CSUM_OFF = 12'h006;
  localparam logic [LEN_W-1:0] SCTP_CRC_OFF = 12'h008;

  // Layer-4 type codes
  localparam logic [1:0] L4_UDP = 2'h0;
  localparam logic [1:0] L4_TCP = 2'h1;
  localparam logic [1:0] L4_SCTP = 2'h2;

  // Reflected CRC polynomials and seed
  localparam logic [31:0] POLY_ETH = 32'hEDB88320;
  localparam logic [31:0] POLY_SCTP = 32'h82F63B78;
  localparam logic [31:0] CRC_SEED = 32'hFFFFFFFF;
  localparam logic [2:0] FCS_BYTES = 3'h4;

  // Statistics register offsets and reset value
  localparam logic [3:0] STAT_PKT_ADDR = 4'h0;
  localparam logic [3:0] STAT_BYTE_LO_ADDR = 4'h4;
  localparam logic [3:0] STAT_BYTE_HI_ADDR = 4'h8;
  localparam logic [63:0] STAT_RESET = 64'h0;

  // Counter visibility bound; counters update one cycle after the event
  localparam int STAT_MAX_DELAY_NS = 1000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int STAT_MAX_DELAY_CYC = STAT_MAX_DELAY_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    S_RECV  = 3'b000,
    S_FOLD  = 3'b001,
    S_PATCH = 3'b010,
    S_SEND  = 3'b011,
    S_FCS   = 3'b100
  } state_e;

  // One byte of a reflected CRC32
  function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [7:0] data,
                                           input logic [31:0] poly);
    logic [31:0] c;
    c = crc ^ {24'h000000, data};
    for (int k = 0; k < 8; k++)
    begin
      c = c[0] ? ((c >> 1) ^ poly) : (c >> 1);
    end
    return c;
  endfunction : crc_step

  // End-around carry fold to 16 bits
  function automatic logic [15:0] fold16(input logic [31:0] s);
    logic [16:0] t;
    logic [16:0] r;
    t = {1'b0, s[15:0]} + {1'b0, s[31:16]};
    r = {1'b0, t[15:0]} + {16'h0000, t[16]};
    return r[15:0];
  endfunction : fold16

endpackage : csum_pkg

// *** rtl/csum_if.sv ***
`timescale 1ns/1ps
interface csum_if;
  import csum_pkg::*;
  // Per-packet context, held stable by the feeder while the packet enters
  logic segmentation_enable;
  logic crc_append_enable;
  logic ip_csum_insert;
  logic l4_csum_insert;
  logic ipv4_type_flag;
  logic tunneled;
  logic outer_ip_checksum_enable;
  logic [1:0] l4_type;
  logic [6:0] l2_header_length;
  logic [8:0] ip_header_length;
  logic [8:0] outer_ip_header_length;
  logic [7:0] tunnel_header_length;
  // Fetched bytes in
  logic in_valid;
  logic in_ready;
  logic [7:0] in_data;
  logic in_last;
  // Bytes out to the MAC
  logic out_valid;
  logic out_ready;
  logic [7:0] out_data;
  logic out_last;
  // Statistics read port
  logic stat_rd;
  logic [3:0] stat_addr;
  logic [31:0] stat_rdata;

  modport engine (
    input segmentation_enable, crc_append_enable, ip_csum_insert, l4_csum_insert, ipv4_type_flag,
    input tunneled, outer_ip_checksum_enable, l4_type, l2_header_length, ip_header_length,
    input outer_ip_header_length, tunnel_header_length, in_valid, in_data, in_last, out_ready,
    input stat_rd, stat_addr,
    output in_ready, out_valid, out_data, out_last, stat_rdata
  );

  modport feeder (
    output segmentation_enable, crc_append_enable, ip_csum_insert, l4_csum_insert, ipv4_type_flag,
    output tunneled, outer_ip_checksum_enable, l4_type, l2_header_length, ip_header_length,
    output outer_ip_header_length, tunnel_header_length, in_valid, in_data, in_last, out_ready,
    output stat_rd, stat_addr,
    input in_ready, out_valid, out_data, out_last, stat_rdata
  );
endinterface : csum_if

// *** rtl/csum_engine.sv ***
`timescale 1ns/1ps
module csum_engine
  import csum_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  csum_if.engine lnk
);

  state_e state;
  logic [7:0] mem [BUF_DEPTH];
  logic [LEN_W-1:0] wr_idx, rd_idx, pkt_len;
  logic [LEN_W-1:0] tun_add, ip_start, ip_end, outer_end, sctp_start;
  logic [31:0] ip_sum, outer_sum, l4_sum, sctp_crc, fcs;
  logic [15:0] ip_ck, outer_ck, l4_ck;
  logic [31:0] sctp_ck;
  logic [LEN_W-1:0] q_ip_field, q_outer_field, q_l4_field, q_sctp_field;
  logic q_ip_en, q_outer_en, q_l4_en, q_udp, q_sctp_en, q_crc_en;
  logic [2:0] fcs_k;
  logic take, step, send_more, fcs_more;
  logic in_ip, in_outer, in_l4, in_sctp;
  logic [63:0] byte_cnt;
  logic [31:0] pkt_cnt, byte_hi_shadow;

  function automatic logic [31:0] word_part(input logic [7:0] b, input logic odd);
    return odd ? {24'h000000, b} : {16'h0000, b, 8'h00};
  endfunction : word_part

  // Range boundaries from the live context; tunnels push the inner IP and TCP/UDP headers back, not the SCTP start
  assign tun_add = lnk.tunneled ? (LEN_W'(lnk.outer_ip_header_length) + LEN_W'(lnk.tunnel_header_length))
                                : '0;
  assign ip_start = LEN_W'(lnk.l2_header_length) + tun_add;
  assign ip_end = ip_start + LEN_W'(lnk.ip_header_length);
  assign outer_end = LEN_W'(lnk.l2_header_length) + LEN_W'(lnk.outer_ip_header_length);
  assign sctp_start = LEN_W'(lnk.l2_header_length) + LEN_W'(lnk.ip_header_length);

  assign take = lnk.in_valid && lnk.in_ready;
  assign lnk.in_ready = (state == S_RECV);
  assign step = !lnk.out_valid || lnk.out_ready;
  assign send_more = (rd_idx < pkt_len);
  assign fcs_more = (fcs_k < FCS_BYTES);

  // The stored checksum field itself counts as zero in the IP sums
  assign in_ip = (wr_idx >= ip_start) && (wr_idx < ip_end) && (wr_idx != ip_start + IP_CSUM_OFF)
                 && (wr_idx != ip_start + IP_CSUM_OFF + 12'h001);
  assign in_outer = (wr_idx >= LEN_W'(lnk.l2_header_length)) && (wr_idx < outer_end)
                    && (wr_idx != LEN_W'(lnk.l2_header_length) + IP_CSUM_OFF)
                    && (wr_idx != LEN_W'(lnk.l2_header_length) + IP_CSUM_OFF + 12'h001);
  assign in_l4 = (wr_idx >= ip_end);
  assign in_sctp = (wr_idx >= sctp_start);

  // Sums build while bytes arrive, so no second pass over the store is needed
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ip_sum <= '0;
      outer_sum <= '0;
      l4_sum <= '0;
      sctp_crc <= CRC_SEED;
    end
    else if (take)
    begin
      ip_sum <= ((wr_idx == '0) ? 32'h0 : ip_sum)
                + (in_ip ? word_part(lnk.in_data, wr_idx[0] ^ ip_start[0]) : 32'h0);
      outer_sum <= ((wr_idx == '0) ? 32'h0 : outer_sum)
                   + (in_outer ? word_part(lnk.in_data, wr_idx[0] ^ lnk.l2_header_length[0]) : 32'h0);
      // Preloaded pseudo-header in the field is summed as-is
      l4_sum <= ((wr_idx == '0) ? 32'h0 : l4_sum)
                + (in_l4 ? word_part(lnk.in_data, wr_idx[0] ^ ip_end[0]) : 32'h0);
      if (in_sctp)
      begin
        sctp_crc <= crc_step((wr_idx == sctp_start) ? CRC_SEED : sctp_crc, lnk.in_data, POLY_SCTP);
      end
    end
  end

  // Byte counting and packet length
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_idx <= '0;
      pkt_len <= '0;
    end
    else if (take)
    begin
      wr_idx <= lnk.in_last ? '0 : wr_idx + 12'h001;
      if (lnk.in_last)
      begin
        pkt_len <= wr_idx + 12'h001;
      end
    end
  end

  // Context is caught on the last byte; the feeder may load the next one after it
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q_ip_field <= '0;
      q_outer_field <= '0;
      q_l4_field <= '0;
      q_sctp_field <= '0;
      q_ip_en <= 1'b0;
      q_outer_en <= 1'b0;
      q_l4_en <= 1'b0;
      q_udp <= 1'b0;
      q_sctp_en <= 1'b0;
      q_crc_en <= 1'b0;
    end
    else if (take && lnk.in_last)
    begin
      q_ip_field <= ip_start + IP_CSUM_OFF;
      q_outer_field <= LEN_W'(lnk.l2_header_length) + IP_CSUM_OFF;
      q_l4_field <= ip_end + ((lnk.l4_type == L4_TCP) ? TCP_CSUM_OFF : UDP_CSUM_OFF);
      q_sctp_field <= sctp_start + SCTP_CRC_OFF;
      q_ip_en <= lnk.ip_csum_insert && lnk.ipv4_type_flag;
      q_outer_en <= lnk.tunneled && lnk.outer_ip_checksum_enable;
      q_l4_en <= lnk.l4_csum_insert && ((lnk.l4_type == L4_TCP) || (lnk.l4_type == L4_UDP));
      q_udp <= (lnk.l4_type == L4_UDP);
      q_sctp_en <= lnk.l4_csum_insert && (lnk.l4_type == L4_SCTP);
      q_crc_en <= lnk.crc_append_enable;
    end
  end

  // Final complement; a UDP result of zero goes out as all ones
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ip_ck <= '0;
      outer_ck <= '0;
      l4_ck <= '0;
      sctp_ck <= '0;
    end
    else if (state == S_FOLD)
    begin
      ip_ck <= ~fold16(ip_sum);
      outer_ck <= ~fold16(outer_sum);
      l4_ck <= (q_udp && (fold16(l4_sum) == 16'hFFFF)) ? 16'hFFFF : ~fold16(l4_sum);
      sctp_ck <= ~sctp_crc;
    end
  end

  // Packet store; only the enabled checksum fields are overwritten
  always_ff @(posedge sys_clk)
  begin
    if (take && (wr_idx < BUF_LEN))
    begin
      mem[IDX_W'(wr_idx)] <= lnk.in_data;
    end
    if (state == S_PATCH)
    begin
      if (q_outer_en)
      begin
        mem[IDX_W'(q_outer_field)] <= outer_ck[15:8];
        mem[IDX_W'(q_outer_field + 12'h001)] <= outer_ck[7:0];
      end
      if (q_ip_en)
      begin
        mem[IDX_W'(q_ip_field)] <= ip_ck[15:8];
        mem[IDX_W'(q_ip_field + 12'h001)] <= ip_ck[7:0];
      end
      if (q_l4_en)
      begin
        mem[IDX_W'(q_l4_field)] <= l4_ck[15:8];
        mem[IDX_W'(q_l4_field + 12'h001)] <= l4_ck[7:0];
      end
      // CRC32c goes out least significant byte first
      if (q_sctp_en)
      begin
        for (int k = 0; k < 4; k++)
        begin
          mem[IDX_W'(q_sctp_field + LEN_W'(k))] <= sctp_ck[8*k +: 8];
        end
      end
    end
  end

  // Sequencing: receive, fold, patch, then release to the MAC
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= S_RECV;
    end
    else
    begin
      unique case (state)
        S_RECV: if (take && lnk.in_last) state <= S_FOLD;
        S_FOLD: state <= S_PATCH;
        S_PATCH: state <= S_SEND;
        S_SEND: if (step && !send_more) state <= q_crc_en ? S_FCS : S_RECV;
        S_FCS: if (step && !fcs_more) state <= S_RECV;
      endcase
    end
  end

  // Output stage; the FCS covers the patched bytes, so it follows the patch
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lnk.out_valid <= 1'b0;
      lnk.out_data <= '0;
      lnk.out_last <= 1'b0;
      rd_idx <= '0;
      fcs_k <= '0;
      fcs <= CRC_SEED;
    end
    else if (state == S_PATCH)
    begin
      rd_idx <= '0;
      fcs_k <= '0;
      fcs <= CRC_SEED;
    end
    else if ((state == S_SEND) && step)
    begin
      lnk.out_valid <= send_more;
      if (send_more)
      begin
        lnk.out_data <= mem[IDX_W'(rd_idx)];
        lnk.out_last <= (rd_idx == pkt_len - 12'h001) && !q_crc_en;
        fcs <= crc_step(fcs, mem[IDX_W'(rd_idx)], POLY_ETH);
        rd_idx <= rd_idx + 12'h001;
      end
    end
    else if ((state == S_FCS) && step)
    begin
      lnk.out_valid <= fcs_more;
      if (fcs_more)
      begin
        lnk.out_data <= ~fcs[8*fcs_k[1:0] +: 8];
        lnk.out_last <= (fcs_k == FCS_BYTES - 3'h1);
        fcs_k <= fcs_k + 3'h1;
      end
    end
  end

  // Statistics: counted as bytes leave; a packet or low-byte read clears that count, and a same-cycle event survives
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pkt_cnt <= STAT_RESET[31:0];
      byte_cnt <= STAT_RESET;
      byte_hi_shadow <= STAT_RESET[31:0];
      lnk.stat_rdata <= '0;
    end
    else
    begin
      if (lnk.stat_rd && (lnk.stat_addr == STAT_PKT_ADDR))
      begin
        pkt_cnt <= {31'h0, lnk.out_valid && lnk.out_ready && lnk.out_last};
      end
      else if (lnk.out_valid && lnk.out_ready && lnk.out_last && (pkt_cnt != 32'hFFFFFFFF))
      begin
        pkt_cnt <= pkt_cnt + 32'h1;
      end
      if (lnk.stat_rd && (lnk.stat_addr == STAT_BYTE_LO_ADDR))
      begin
        byte_cnt <= {63'h0, lnk.out_valid && lnk.out_ready};
        byte_hi_shadow <= byte_cnt[63:32];
      end
      else if (lnk.out_valid && lnk.out_ready && (byte_cnt != 64'hFFFFFFFFFFFFFFFF))
      begin
        byte_cnt <= byte_cnt + 64'h1;
      end
      if (lnk.stat_rd)
      begin
        unique case (lnk.stat_addr)
          STAT_PKT_ADDR: lnk.stat_rdata <= pkt_cnt;
          STAT_BYTE_LO_ADDR: lnk.stat_rdata <= byte_cnt[31:0];
          STAT_BYTE_HI_ADDR: lnk.stat_rdata <= byte_hi_shadow;
          default: lnk.stat_rdata <= 32'h0;
        endcase
      end
      else
      begin
        lnk.stat_rdata <= 32'h0;
      end
    end
  end

endmodule : csum_engine

// *** rtl/csum_feeder.sv ***
`timescale 1ns/1ps
// Fetch side: loads a checked context, feeds bytes, and hands the MAC stream out
module csum_feeder
  import csum_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  csum_if.feeder lnk,
  input wire logic ctx_valid,
  output logic ctx_ready,
  input wire logic [6:0] ctx_l2_len,
  input wire logic [8:0] ctx_ip_len,
  input wire logic [8:0] ctx_outer_len,
  input wire logic [7:0] ctx_tunnel_len,
  input wire logic [7:0] ctx_l4_hdr_len,
  input wire logic [11:0] ctx_pkt_len,
  input wire logic ctx_ipv4,
  input wire logic [1:0] ctx_l4_type,
  input wire logic ctx_tunneled,
  input wire logic ctx_outer_csum,
  input wire logic ctx_ip_insert,
  input wire logic ctx_l4_insert,
  input wire logic ctx_crc_append,
  input wire logic dma_valid,
  output logic dma_ready,
  input wire logic [7:0] dma_data,
  input wire logic dma_last,
  output logic mac_valid,
  input wire logic mac_ready,
  output logic [7:0] mac_data,
  output logic mac_last,
  input wire logic stat_rd,
  input wire logic [3:0] stat_addr,
  output logic [31:0] stat_rdata
);

  logic loaded;
  logic [LEN_W-1:0] cnt, sctp_field, hdr_sum, l3_end, l3_pay;
  logic ip_ok, l4_ok, ip_ins, l4_ins, zero_byte;

  // Legality checks on a context before it is offered
  assign l3_end = LEN_W'(ctx_l2_len) + LEN_W'(ctx_ip_len);
  assign hdr_sum = l3_end + (ctx_tunneled ? LEN_W'(ctx_outer_len) + LEN_W'(ctx_tunnel_len) : '0)
                   + LEN_W'(ctx_l4_hdr_len);
  assign l3_pay = ctx_pkt_len - l3_end;
  assign ip_ok = (LEN_W'(ctx_l2_len) >= L2_LEN_MIN) && (LEN_W'(ctx_l2_len) <= L2_LEN_MAX)
                 && (LEN_W'(ctx_ip_len) <= IP_LEN_MAX) && (l3_end <= IP_END_MAX)
                 && (l3_end < ctx_pkt_len);
  assign l4_ok = ip_ok && (hdr_sum < ctx_pkt_len)
                 && ((ctx_l4_type != L4_SCTP) || ((l3_end >= SCTP_START_MIN) && (l3_pay[1:0] == 2'h0)));
  assign ip_ins = ctx_ip_insert && ip_ok;
  assign l4_ins = ctx_l4_insert && l4_ok;

  // Context registers hold until the last byte of the packet is taken
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      loaded <= 1'b0;
      lnk.segmentation_enable <= 1'b0;
      lnk.crc_append_enable <= 1'b0;
      lnk.ip_csum_insert <= 1'b0;
      lnk.l4_csum_insert <= 1'b0;
      lnk.ipv4_type_flag <= 1'b0;
      lnk.tunneled <= 1'b0;
      lnk.outer_ip_checksum_enable <= 1'b0;
      lnk.l4_type <= L4_UDP;
      lnk.l2_header_length <= '0;
      lnk.ip_header_length <= '0;
      lnk.outer_ip_header_length <= '0;
      lnk.tunnel_header_length <= '0;
      sctp_field <= '0;
    end
    else if (ctx_valid && ctx_ready)
    begin
      loaded <= 1'b1;
      lnk.segmentation_enable <= 1'b0;
      lnk.crc_append_enable <= ctx_crc_append || ip_ins || l4_ins;
      lnk.ip_csum_insert <= ip_ins;
      lnk.l4_csum_insert <= l4_ins;
      lnk.ipv4_type_flag <= ctx_ipv4;
      lnk.tunneled <= ctx_tunneled;
      lnk.outer_ip_checksum_enable <= ctx_outer_csum && ip_ok;
      lnk.l4_type <= ctx_l4_type;
      lnk.l2_header_length <= ctx_l2_len;
      lnk.ip_header_length <= ctx_ip_len;
      lnk.outer_ip_header_length <= ctx_outer_len;
      lnk.tunnel_header_length <= ctx_tunnel_len;
      sctp_field <= (l4_ins && (ctx_l4_type == L4_SCTP)) ? l3_end + SCTP_CRC_OFF : '1;
    end
    else if (lnk.in_valid && lnk.in_ready && lnk.in_last)
    begin
      loaded <= 1'b0;
    end
  end

  // Byte position inside the packet
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= '0;
    end
    else if (lnk.in_valid && lnk.in_ready)
    begin
      cnt <= lnk.in_last ? '0 : cnt + 12'h001;
    end
  end

  // The CRC field is forced to zero on the way in
  assign zero_byte = (cnt >= sctp_field) && (cnt < sctp_field + 12'h004);
  assign ctx_ready = !loaded;
  assign lnk.in_valid = dma_valid && loaded;
  assign lnk.in_data = zero_byte ? 8'h00 : dma_data;
  assign lnk.in_last = dma_last;
  assign dma_ready = lnk.in_ready && loaded;

  // MAC and statistics pass straight through
  assign mac_valid = lnk.out_valid;
  assign mac_data = lnk.out_data;
  assign mac_last = lnk.out_last;
  assign lnk.out_ready = mac_ready;
  assign lnk.stat_rd = stat_rd;
  assign lnk.stat_addr = stat_addr;
  assign stat_rdata = lnk.stat_rdata;

endmodule : csum_feeder

// *** sim/csum_properties.sv ***
`timescale 1ns/1ps
// Watches the link between feeder and engine
module csum_properties
  import csum_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic segmentation_enable,
  input wire logic crc_append_enable,
  input wire logic ip_csum_insert,
  input wire logic l4_csum_insert,
  input wire logic [1:0] l4_type,
  input wire logic [6:0] l2_header_length,
  input wire logic [8:0] ip_header_length,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic in_last,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic stat_rd,
  input wire logic [31:0] stat_rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Header end widened so the sum cannot wrap
  logic [9:0] hsum;
  logic take;
  assign hsum = 10'(l2_header_length) + 10'(ip_header_length);
  assign take = in_valid && in_ready;

  a_single_send : assert property (!segmentation_enable)
    else $error("segmentation requested");
  a_crc_follows : assert property ((ip_csum_insert || l4_csum_insert) |-> crc_append_enable)
    else $error("insert without frame check");
  a_l2_window : assert property (take && ip_csum_insert |-> 12'(l2_header_length) >= L2_LEN_MIN)
    else $error("ip insert with short l2 length");
  a_ip_end : assert property (take && ip_csum_insert |-> hsum <= 10'(IP_END_MAX))
    else $error("ip insert past header limit");
  a_sctp_start : assert property (take && l4_csum_insert && l4_type == L4_SCTP |-> hsum >= 10'(SCTP_START_MIN))
    else $error("sctp insert with early start");
  a_fold_gap : assert property (take && in_last |=> !out_valid [*3] ##1 out_valid)
    else $error("output start not four cycles after last byte");
  a_out_hold : assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last))
    else $error("output changed while stalled");
  a_busy_closed : assert property (out_valid |-> !in_ready)
    else $error("input open while sending");
  a_stat_quiet : assert property (!stat_rd |=> stat_rdata == 32'h0)
    else $error("read data without read");

  c_sctp_pkt : cover property (take && in_last && l4_csum_insert && l4_type == L4_SCTP);
  c_out_stall : cover property (out_valid && !out_ready);
  c_out_done : cover property (out_valid && out_ready && out_last);
endmodule : csum_properties

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb
  import csum_pkg::*;
;
  logic sys_clk, rst_b, ctx_valid, ctx_ready, ctx_ipv4, ctx_tunneled, ctx_outer_csum;
  logic ctx_ip_insert, ctx_l4_insert, ctx_crc_append, dma_valid, dma_ready, dma_last;
  logic mac_valid, mac_ready, mac_last, stat_rd, stall, got_last;
  logic [6:0] ctx_l2_len;
  logic [8:0] ctx_ip_len, ctx_outer_len;
  logic [7:0] ctx_tunnel_len, ctx_l4_hdr_len, dma_data, mac_data;
  logic [11:0] ctx_pkt_len;
  logic [1:0] ctx_l4_type;
  logic [3:0] stat_addr;
  logic [31:0] stat_rdata;
  logic [7:0] in_q[$], exp_q[$], rx_q[$];
  int fail_count = 0;
  int checks_done = 0;
  int pkts = 0;
  int octets = 0;

  csum_if csum_if_i ();
  csum_engine csum_engine_i (.sys_clk, .rst_b, .lnk(csum_if_i));
  csum_feeder csum_feeder_i (.sys_clk, .rst_b, .lnk(csum_if_i), .ctx_valid, .ctx_ready, .ctx_l2_len, .ctx_ip_len,
    .ctx_outer_len, .ctx_tunnel_len, .ctx_l4_hdr_len, .ctx_pkt_len, .ctx_ipv4, .ctx_l4_type, .ctx_tunneled,
    .ctx_outer_csum, .ctx_ip_insert, .ctx_l4_insert, .ctx_crc_append, .dma_valid, .dma_ready, .dma_data,
    .dma_last, .mac_valid, .mac_ready, .mac_data, .mac_last, .stat_rd, .stat_addr, .stat_rdata);
  csum_properties csum_properties_i (.sys_clk, .rst_b,
    .segmentation_enable(csum_if_i.segmentation_enable), .crc_append_enable(csum_if_i.crc_append_enable),
    .ip_csum_insert(csum_if_i.ip_csum_insert), .l4_csum_insert(csum_if_i.l4_csum_insert),
    .l4_type(csum_if_i.l4_type), .l2_header_length(csum_if_i.l2_header_length),
    .ip_header_length(csum_if_i.ip_header_length), .in_valid(csum_if_i.in_valid),
    .in_ready(csum_if_i.in_ready), .in_last(csum_if_i.in_last), .out_valid(csum_if_i.out_valid),
    .out_ready(csum_if_i.out_ready), .out_data(csum_if_i.out_data), .out_last(csum_if_i.out_last),
    .stat_rd(csum_if_i.stat_rd), .stat_rdata(csum_if_i.stat_rdata));

  // 25 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Collects what the MAC takes; stall halves its rate to exercise holding
  always @(posedge sys_clk)
  begin
    if (mac_valid && mac_ready)
    begin
      rx_q.push_back(mac_data);
      if (mac_last) got_last <= 1'b1;
    end
    mac_ready <= !stall || !mac_ready;
  end

  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (e !== g)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task limit(input bit hit);
    if (hit)
    begin
      chk("wait bound", 32'h0, 32'h1);
      wrap_up();
    end
  endtask : limit

  // Folded one's complement over expected bytes; odd tail padded low
  function automatic logic [15:0] ocs(input int a, input int b);
    logic [31:0] s;
    s = 32'h0;
    for (int i = a; i < b; i += 2) s += {exp_q[i], (i + 1 < b) ? exp_q[i + 1] : 8'h00};
    while (s[31:16] != 16'h0) s = s[15:0] + s[31:16];
    return ~s[15:0];
  endfunction : ocs

  function automatic logic [31:0] crc32(input int a, input int b, input logic [31:0] p);
    logic [31:0] c;
    c = CRC_SEED;
    for (int i = a; i < b; i++)
    begin
      c = c ^ {24'h000000, exp_q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ p : c >> 1;
    end
    return ~c;
  endfunction : crc32

  // Sends one packet and compares the MAC stream with the model of the rules
  task run(input logic [6:0] l2, input logic [8:0] ip, input logic [11:0] len, input logic v4,
           input logic [1:0] l4t, input logic ii, input logic li, input logic fc);
    int n, s, o, t;
    bit ei, el, ok;
    logic [15:0] cs;
    logic [31:0] c;
    // Tunnels push the inner IP and TCP/UDP headers back, not SCTP; the IP length checks use l2 and ip alone, the L4 header check adds the tunnel
    t = ctx_tunneled ? ctx_outer_len + ctx_tunnel_len : 0;
    s = l2 + ip;
    in_q = {};
    for (n = 0; n < len; n++) in_q.push_back(8'(n * 29 + 5));
    if (l4t == L4_SCTP) for (n = 8; n < 12; n++) in_q[s + n] = 8'h00;
    // Illegal lengths drop the insert silently
    ok = l2 >= 7'h0E && s <= 638 && s < len;
    ei = ii && v4 && ok;
    el = li && ok && s + t + 20 < len && (l4t != L4_SCTP || (s >= 26 && (len - s) % 4 == 0));
    exp_q = in_q;
    if (ctx_tunneled && ctx_outer_csum && ok)
    begin
      {exp_q[l2 + 10], exp_q[l2 + 11]} = 16'h0000;
      {exp_q[l2 + 10], exp_q[l2 + 11]} = ocs(l2, l2 + ctx_outer_len);
    end
    if (ei)
    begin
      {exp_q[l2 + t + 10], exp_q[l2 + t + 11]} = 16'h0000;
      {exp_q[l2 + t + 10], exp_q[l2 + t + 11]} = ocs(l2 + t, s + t);
    end
    if (el && l4t == L4_SCTP)
      {exp_q[s + 11], exp_q[s + 10], exp_q[s + 9], exp_q[s + 8]} = crc32(s, len, POLY_SCTP);
    else if (el)
    begin
      o = (l4t == L4_TCP) ? 16 : 6;
      cs = ocs(s + t, len);
      {exp_q[s + t + o], exp_q[s + t + o + 1]} = (cs == 16'h0000 && l4t == L4_UDP) ? 16'hFFFF : cs;
    end
    c = crc32(0, len, POLY_ETH);
    // A surviving IP or L4 insert forces the frame check on, even without the IPv4 flag; the outer IP checksum does not
    if (fc || (ii && ok) || el) for (n = 0; n < 4; n++) exp_q.push_back(c[8 * n +: 8]);
    got_last = 1'b0;
    rx_q = {};
    ctx_l2_len <= l2;
    ctx_ip_len <= ip;
    ctx_pkt_len <= len;
    ctx_ipv4 <= v4;
    ctx_l4_type <= l4t;
    ctx_ip_insert <= ii;
    ctx_l4_insert <= li;
    ctx_crc_append <= fc;
    ctx_valid <= 1'b1;
    @(posedge sys_clk);
    ctx_valid <= 1'b0;
    for (int i = 0; i < len; i++)
    begin
      dma_valid <= 1'b1;
      dma_data <= in_q[i];
      dma_last <= (i == len - 1);
      n = 0;
      do @(negedge sys_clk); while (!dma_ready && ++n < 400);
      limit(n >= 400);
      @(posedge sys_clk);
    end
    dma_valid <= 1'b0;
    dma_last <= 1'b0;
    for (n = 0; !got_last && n < 5000; n++) @(posedge sys_clk);
    limit(n >= 5000);
    chk("length", exp_q.size(), rx_q.size());
    for (n = 0; n < exp_q.size() && rx_q[n] === exp_q[n]; n++);
    chk("first bad byte", exp_q.size(), n);
    pkts++;
    octets += rx_q.size();
    $display("packet of %0d bytes done", len);
  endtask : run

  task rd(input logic [3:0] a, input logic [31:0] e);
    stat_rd <= 1'b1;
    stat_addr <= a;
    @(posedge sys_clk);
    stat_rd <= 1'b0;
    @(negedge sys_clk);
    chk("statistics", e, stat_rdata);
    @(posedge sys_clk);
  endtask : rd

  // Main sequence; tunnel fields stay off until the last packet
  initial
  begin
    {ctx_valid, ctx_l2_len, ctx_ip_len, ctx_outer_len, ctx_tunnel_len, ctx_pkt_len, ctx_ipv4, ctx_l4_type} = '0;
    {ctx_tunneled, ctx_outer_csum, ctx_ip_insert, ctx_l4_insert, ctx_crc_append} = '0;
    {dma_valid, dma_data, dma_last, stat_rd, stat_addr, stall, got_last} = '0;
    ctx_l4_hdr_len = 8'h14;
    mac_ready = 1'b1;
    rst_b = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    run(7'h0E, 9'h014, 12'h03C, 1'b1, L4_TCP, 1'b0, 1'b0, 1'b0);
    stall <= 1'b1;
    run(7'h0E, 9'h014, 12'h050, 1'b1, L4_TCP, 1'b1, 1'b1, 1'b1);
    run(7'h12, 9'h018, 12'h047, 1'b0, L4_UDP, 1'b1, 1'b1, 1'b1);
    run(7'h0E, 9'h014, 12'h04E, 1'b1, L4_SCTP, 1'b0, 1'b1, 1'b1);
    stall <= 1'b0;
    run(7'h7F, 9'h1FF, 12'h2BC, 1'b1, L4_TCP, 1'b1, 1'b0, 1'b1);
    run(7'h0D, 9'h014, 12'h03C, 1'b1, L4_TCP, 1'b1, 1'b0, 1'b1);
    run(7'h0E, 9'h008, 12'h03E, 1'b0, L4_SCTP, 1'b0, 1'b1, 1'b1);
    // Tunnel context is settled one edge before the model reads it
    ctx_tunneled <= 1'b1;
    ctx_outer_csum <= 1'b1;
    ctx_outer_len <= 9'h014;
    ctx_tunnel_len <= 8'h08;
    @(posedge sys_clk);
    run(7'h0E, 9'h014, 12'h064, 1'b1, L4_UDP, 1'b1, 1'b1, 1'b1);
    rd(STAT_BYTE_LO_ADDR, 32'(octets));
    rd(STAT_BYTE_HI_ADDR, 32'h0);
    rd(STAT_PKT_ADDR, 32'(pkts));
    rd(STAT_PKT_ADDR, 32'h0);
    rd(STAT_BYTE_LO_ADDR, 32'h0);
    rd(4'hC, 32'h0);
    $display("statistics reads done");
    wrap_up();
  end
endmodule : tb
